/* File: logic/cmn_pkg.sv */
// Package for the cascaded mantissa normalizer controller
package cmn_pkg;
  // Register offsets (word index on the software port)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_BLOCK_MAX = 4'h2;
  localparam logic [3:0] REG_BLOCK_APPLY = 4'h3;
  // Control field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SIGN_BIT = 2;
  localparam int CTRL_HALF_BIT = 3;
  // Status field positions
  localparam int STAT_COUNT_LSB = 0;
  localparam int STAT_ROW_LSB = 8;
  localparam int STAT_NONE_BIT = 16;
  // Reset values
  localparam logic [1:0] CTRL_MODE_RST = 2'h0;
  localparam logic [4:0] CODE_ZERO = 5'h00;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  // Slice encoder geometry
  localparam int CODE_W = 5;
  localparam int LOW_W = 4;
  localparam logic [3:0] MAX_CASCADE_SHIFT = 4'hf;
  // Operating arrangements
  typedef enum logic [1:0] {
    MODE_CASCADE = 2'b00,
    MODE_BANK = 2'b01,
    MODE_BLOCK = 2'b10,
    MODE_IDLE = 2'b11
  } cmn_mode_t;
  // Static controls driven onto every slice
  typedef struct packed {
    logic fill_mode;
    logic right_left;
    logic auto_normalize_select;
    logic output_half_select;
    logic sign;
  } cmn_slice_ctl_t;
endpackage

/* File: logic/cmn_ctrl.sv */
// Controller that drives an array of cascadable barrel-shifter slices
// Summary of operation
// RQ1: Lower slices share sixteen input bits with their more significant neighbour.
// RQ2: Slices run fill mode, left shift, with automatic normalize held off.
// RQ3: Outside block mode every slice routes its upper sixteen shifter outputs to its pins.
// RQ4: Top slice encoder count feeds shift code of all slices, top included.
// RQ5: Shift code MSB is held low in simple cascade, capping shift at fifteen.
// RQ6: Top slice encoder gives exact normalizing count when leader is in top sixteen.
// RQ7: Top sixteen all zero gives the full fifteen shift, else zero to fifteen.
// RQ8: Row inputs step sixteen positions left from one row to the next.
// RQ9: Only the selected row drives the shared three-state result bus.
// RQ10: Row top slice drives encoder MSB low when leader is in its top sixteen.
// RQ11: Highest-priority row with leader in its top sixteen is enabled onto bus.
// RQ12: Total count is row number above the selected row's low four count bits.
// RQ13: Least significant slice per row stays enabled; row select drives its code MSB.
// RQ14: Deselected row's least significant slice gets code above fifteen, giving zero fill.
// RQ15: Lower rows may be partly populated since their low bits are zero filled.
// RQ16: Block mode keeps auto normalize off and takes each element's encoder count.
// RQ17: The largest shift distance of the current vector pass is retained.
// RQ18: Next pass applies the saved shift code unchanged to every element.
// RQ19: Measuring the next pass and applying the saved shift may overlap.
// RQ20: Encoder gives a five-bit count that left-aligns the first non-zero bit.
// RQ21: Input bits are exclusive-ORed with sign ahead of the encoder.
// RQ22: Left fill mode fills vacated low positions with zero.
// RQ23: Half select routes upper or lower sixteen shifter outputs to the pins.
// RQ24: Block maximum is cleared at the start of each vector pass.
`timescale 1ns/1ps
`default_nettype none
module cmn_ctrl #(
  parameter int ROWS = 4, // Banks in the single-pass arrangement
  parameter int ROW_W = (ROWS > 1) ? $clog2(ROWS) : 1 // Row number width
) (
  input wire logic core_clk, // System clock, 10 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [3:0] reg_addr, // Register word index
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic [cmn_pkg::CODE_W-1:0] encoder_shift_count_out, // Top slice encoder count
  input wire logic [ROWS-1:0] encoder_count_msb_out, // Per-row top slice count MSB
  input wire logic [ROWS*cmn_pkg::LOW_W-1:0] encoder_count_low_out, // Per-row low counts
  input wire logic elem_valid_in, // Element present at slice inputs
  input wire logic pass_start_in, // Rises at start of a vector pass
  output logic [cmn_pkg::CODE_W-1:0] shift_code_in, // Shift code to all slices
  output cmn_pkg::cmn_slice_ctl_t slice_ctl, // Static slice controls
  output logic [ROWS-1:0] row_oe_n, // Row output enables, low drives bus
  output logic [ROWS-1:0] shift_code_msb_in, // Code MSB of each row's low slice
  output logic [ROW_W+cmn_pkg::LOW_W-1:0] auto_normalize_select_count, // Total normalization shift
  output logic auto_normalize_select_none // No row holds a leading bit
);

  // Synchroniser stages for every pin input
  logic [cmn_pkg::CODE_W-1:0] cnt_s1_reg, cnt_s2_reg;
  logic [ROWS-1:0] msb_s1_reg, msb_s2_reg;
  logic [ROWS*cmn_pkg::LOW_W-1:0] low_s1_reg, low_s2_reg;
  logic valid_s1_reg, valid_s2_reg;
  logic start_s1_reg, start_s2_reg, start_d_reg;

  // Software state
  cmn_pkg::cmn_mode_t mode_reg;
  logic sign_reg;
  logic half_reg;
  logic [cmn_pkg::CODE_W-1:0] block_max_reg;
  logic [cmn_pkg::CODE_W-1:0] block_apply_reg;
  logic [cmn_pkg::CODE_W-1:0] block_max_next;
  logic pass_start;
  logic [ROW_W-1:0] sel_row;
  logic sel_none;
  logic [cmn_pkg::LOW_W-1:0] sel_low;
  logic [cmn_pkg::CODE_W-1:0] code_next;
  logic wr_ctrl;
  logic wr_apply;

  // Lowest-index row whose top slice reports a leading bit in its top sixteen
  function automatic logic [ROW_W:0] pick_row(input logic [ROWS-1:0] msb);
    logic [ROW_W:0] r;
    r = {1'b1, ROW_W'(ROWS - 1)};
    for (int i = ROWS - 1; i >= 0; i--)
    begin
      if (!msb[i])
      begin
        r = {1'b0, ROW_W'(i)};
      end
    end
    return r;
  endfunction

  // Cascade shift: empty top sixteen gives the full fifteen, not a wrapped code
  function automatic logic [cmn_pkg::LOW_W-1:0] cascade_shift(
    input logic [cmn_pkg::CODE_W-1:0] cnt
  );
    logic [cmn_pkg::LOW_W-1:0] s;
    s = cnt[cmn_pkg::LOW_W-1:0]; // see RQ6
    if (cnt[cmn_pkg::LOW_W])
    begin
      s = cmn_pkg::MAX_CASCADE_SHIFT; // see RQ7
    end
    return s;
  endfunction

  // Write strobe aimed at one register word
  function automatic logic reg_hit(
    input logic strobe,
    input logic [3:0] addr,
    input logic [3:0] idx
  );
    return strobe && (addr == idx);
  endfunction

  // Register write decode
  assign wr_ctrl = reg_hit(reg_wr, reg_addr, cmn_pkg::REG_CTRL);
  assign wr_apply = reg_hit(reg_wr, reg_addr, cmn_pkg::REG_BLOCK_APPLY);

  // Two-flop synchronisers on all pin inputs
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cnt_s1_reg <= cmn_pkg::CODE_ZERO;
      cnt_s2_reg <= cmn_pkg::CODE_ZERO;
      msb_s1_reg <= '1;
      msb_s2_reg <= '1;
      low_s1_reg <= '0;
      low_s2_reg <= '0;
      valid_s1_reg <= 1'b0;
      valid_s2_reg <= 1'b0;
      start_s1_reg <= 1'b0;
      start_s2_reg <= 1'b0;
      start_d_reg <= 1'b0;
    end
    else
    begin
      cnt_s1_reg <= encoder_shift_count_out;
      cnt_s2_reg <= cnt_s1_reg;
      msb_s1_reg <= encoder_count_msb_out;
      msb_s2_reg <= msb_s1_reg;
      low_s1_reg <= encoder_count_low_out;
      low_s2_reg <= low_s1_reg;
      valid_s1_reg <= elem_valid_in;
      valid_s2_reg <= valid_s1_reg;
      start_s1_reg <= pass_start_in;
      start_s2_reg <= start_s1_reg;
      start_d_reg <= start_s2_reg;
    end
  end

  // Pass start is the rising edge of the synchronised level
  assign pass_start = start_s2_reg && !start_d_reg;

  // Row priority and the selected row's low count bits
  always_comb
  begin
    logic [ROW_W:0] pr;
    pr = pick_row(msb_s2_reg); // see RQ11
    sel_row = pr[ROW_W-1:0];
    sel_none = pr[ROW_W];
    sel_low = low_s2_reg[sel_row*cmn_pkg::LOW_W +: cmn_pkg::LOW_W];
  end

  // Software writes to the control register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      mode_reg <= cmn_pkg::cmn_mode_t'(cmn_pkg::CTRL_MODE_RST);
      sign_reg <= 1'b0;
      half_reg <= 1'b1;
    end
    else if (wr_ctrl)
    begin
      mode_reg <= cmn_pkg::cmn_mode_t'(reg_wdata[cmn_pkg::CTRL_MODE_LSB +: 2]);
      sign_reg <= reg_wdata[cmn_pkg::CTRL_SIGN_BIT];
      half_reg <= reg_wdata[cmn_pkg::CTRL_HALF_BIT];
    end
  end

  // Running maximum of element shift distances within a pass
  always_comb
  begin
    block_max_next = block_max_reg;
    if (pass_start)
    begin
      block_max_next = cmn_pkg::CODE_ZERO; // see RQ24
    end
    if (valid_s2_reg && mode_reg == cmn_pkg::MODE_BLOCK
        && cnt_s2_reg > block_max_next)
    begin
      block_max_next = cnt_s2_reg; // see RQ16 see RQ17
    end
  end

  // Block maximum, restarted by each pass
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      block_max_reg <= cmn_pkg::CODE_ZERO;
    end
    else
    begin
      block_max_reg <= block_max_next;
    end
  end

  // Shift saved for the following pass; a software write wins
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      block_apply_reg <= cmn_pkg::CODE_ZERO;
    end
    else if (wr_apply)
    begin
      block_apply_reg <= reg_wdata[cmn_pkg::CODE_W-1:0];
    end
    else if (pass_start)
    begin
      block_apply_reg <= block_max_reg; // see RQ18 see RQ19
    end
  end

  // Shift code chosen per arrangement
  always_comb
  begin
    case (mode_reg)
      cmn_pkg::MODE_CASCADE:
        code_next = {1'b0, cascade_shift(cnt_s2_reg)}; // see RQ4 see RQ5 see RQ7
      cmn_pkg::MODE_BLOCK:
        code_next = block_apply_reg; // see RQ18
      default:
        code_next = cmn_pkg::CODE_ZERO;
    endcase
  end

  // Shift code to every slice
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      shift_code_in <= cmn_pkg::CODE_ZERO;
    end
    else
    begin
      shift_code_in <= code_next;
    end
  end

  // Static slice controls, all from flip-flops
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      slice_ctl <= '{fill_mode: 1'b1, right_left: 1'b0, auto_normalize_select: 1'b0,
                     output_half_select: 1'b1, sign: 1'b0};
    end
    else
    begin
      slice_ctl.fill_mode <= 1'b1; // see RQ2 see RQ22
      slice_ctl.right_left <= 1'b0; // see RQ2
      slice_ctl.auto_normalize_select <= 1'b0; // see RQ2 see RQ16
      slice_ctl.output_half_select <=
        (mode_reg == cmn_pkg::MODE_BLOCK) ? half_reg : 1'b1; // see RQ3 see RQ23
      slice_ctl.sign <= sign_reg; // see RQ21
    end
  end

  // Row bus enables and low slice code MSBs, all rows off outside bank mode
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || mode_reg != cmn_pkg::MODE_BANK)
    begin
      row_oe_n <= '1;
      shift_code_msb_in <= '1;
    end
    else
    begin
      for (int i = 0; i < ROWS; i++)
      begin
        row_oe_n[i] <= (ROW_W'(i) != sel_row); // see RQ9 see RQ11 see RQ13
        shift_code_msb_in[i] <= (ROW_W'(i) != sel_row); // see RQ13 see RQ14 see RQ15
      end
    end
  end

  // Total shift count: row number above selected low bits in bank mode, cascade shift otherwise
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      auto_normalize_select_count <= '0;
      auto_normalize_select_none <= 1'b0;
    end
    else if (mode_reg == cmn_pkg::MODE_BANK)
    begin
      auto_normalize_select_count <= {sel_row, sel_low}; // see RQ8 see RQ10 see RQ12
      auto_normalize_select_none <= sel_none;
    end
    else
    begin
      auto_normalize_select_count <= {ROW_W'(0), cascade_shift(cnt_s2_reg)}; // see RQ6 see RQ20
      auto_normalize_select_none <= cnt_s2_reg[cmn_pkg::LOW_W]; // see RQ7
    end
  end

  // Read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || !reg_rd)
    begin
      reg_rdata <= cmn_pkg::RDATA_ZERO;
    end
    else if (reg_addr == cmn_pkg::REG_CTRL)
    begin
      reg_rdata <= cmn_pkg::RDATA_ZERO;
      reg_rdata[cmn_pkg::CTRL_MODE_LSB +: 2] <= mode_reg;
      reg_rdata[cmn_pkg::CTRL_SIGN_BIT] <= sign_reg;
      reg_rdata[cmn_pkg::CTRL_HALF_BIT] <= half_reg;
    end
    else if (reg_addr == cmn_pkg::REG_STATUS)
    begin
      reg_rdata <= cmn_pkg::RDATA_ZERO;
      reg_rdata[cmn_pkg::STAT_COUNT_LSB +: ROW_W+cmn_pkg::LOW_W] <= auto_normalize_select_count;
      reg_rdata[cmn_pkg::STAT_ROW_LSB +: ROW_W] <= sel_row;
      reg_rdata[cmn_pkg::STAT_NONE_BIT] <= auto_normalize_select_none;
    end
    else if (reg_addr == cmn_pkg::REG_BLOCK_MAX)
    begin
      reg_rdata <= {27'h0, block_max_reg};
    end
    else if (reg_addr == cmn_pkg::REG_BLOCK_APPLY)
    begin
      reg_rdata <= {27'h0, block_apply_reg};
    end
    else
    begin
      reg_rdata <= cmn_pkg::RDATA_ZERO;
    end
  end

endmodule // cmn_ctrl
`default_nettype wire

/* File: bench/cmn_slice_model.sv */
// Encoder side of the shifter slice array
`timescale 1ns/1ps
`default_nettype none
module cmn_slice_model #(
  parameter int ROWS = 4
) (
  input wire logic [63:0] mant, // Word at the slice inputs
  input wire logic sign, // Sign input of all slices
  output logic [4:0] top_count, // Top slice count
  output logic [ROWS-1:0] msb, // Row count MSBs
  output logic [ROWS*4-1:0] low // Row low counts
);
  logic [63:0] sh;
  logic [4:0] c;
  function automatic logic [4:0] enc(input logic [31:0] v);
    enc = 5'h1f;
    for (int i = 0; i < 32; i++)
      if (v[i])
        enc = 5'(31 - i);
  endfunction
  // Rows see the word stepped sixteen places left, zero fill below
  always_comb
  begin
    top_count = enc(mant[63:32] ^ {32{sign}});
    for (int r = 0; r < ROWS; r++)
    begin
      sh = mant << (16 * r);
      c = enc(sh[63:32] ^ {32{sign}});
      msb[r] = c[4];
      low[r*4 +: 4] = c[3:0];
    end
  end
endmodule // cmn_slice_model
`default_nettype wire

/* File: bench/cmn_ctrl_props.sv */
// Port checker for the normalizer controller
`timescale 1ns/1ps
`default_nettype none
module cmn_ctrl_props #(
  parameter int ROWS = 4,
  parameter int ROW_W = 2
) (
  input wire logic core_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic [ROWS-1:0] encoder_count_msb_out, // Row flags
  input wire logic [ROWS*cmn_pkg::LOW_W-1:0] encoder_count_low_out, // Row counts
  input wire logic [cmn_pkg::CODE_W-1:0] shift_code_in, // Code
  input wire cmn_pkg::cmn_slice_ctl_t slice_ctl, // Controls
  input wire logic [ROWS-1:0] row_oe_n, // Row enables
  input wire logic [ROWS-1:0] shift_code_msb_in, // Low slice MSB
  input wire logic [ROW_W+cmn_pkg::LOW_W-1:0] auto_normalize_select_count, // Count
  input wire logic auto_normalize_select_none // No leader
);
  logic [ROWS*5-1:0] in_q;
  logic [2:0] stab;
  int sel;
  logic sel_ok;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Cycles the row inputs have held still
  always_ff @(posedge core_clk)
  begin
    in_q <= {encoder_count_msb_out, encoder_count_low_out};
    if (sys_rst || in_q != {encoder_count_msb_out, encoder_count_low_out})
      stab <= 3'h0;
    else if (stab != 3'h7)
      stab <= stab + 3'h1;
  end
  // First row with its leader in range, else the last
  always_comb
  begin
    sel = ROWS - 1;
    for (int i = ROWS - 1; i >= 0; i--)
      if (!encoder_count_msb_out[i])
        sel = i;
    sel_ok = stab >= 3'h3 && !(&row_oe_n)
      && in_q == {encoder_count_msb_out, encoder_count_low_out};
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  a_fill_left: assert property (
    slice_ctl.fill_mode && !slice_ctl.right_left && !slice_ctl.auto_normalize_select)
    else $error("slice controls wrong");
  a_oe_onehot: assert property ($onehot0(~row_oe_n))
    else $error("two rows on bus");
  a_msb_oe: assert property (shift_code_msb_in == row_oe_n)
    else $error("row code msb wrong");
  a_row_pick: assert property (sel_ok |-> row_oe_n == ~(ROWS'(1) << sel))
    else $error("wrong row selected");
  a_bank_count: assert property (sel_ok |->
    auto_normalize_select_count == {ROW_W'(sel), encoder_count_low_out[sel*4 +: 4]})
    else $error("bank count wrong");
  a_none_flag: assert property (sel_ok |-> auto_normalize_select_none == &encoder_count_msb_out)
    else $error("none flag wrong");
  a_reset_out: assert property (disable iff (1'b0) sys_rst |=> &row_oe_n &&
    shift_code_in == 5'h00 && slice_ctl.output_half_select)
    else $error("reset outputs wrong");
  c_bank: cover property (!(&row_oe_n[ROWS-2:0]));
  c_none: cover property (auto_normalize_select_none);
  c_read: cover property ($past(reg_rd) && reg_rdata != 32'h0);
endmodule // cmn_ctrl_props
bind cmn_ctrl cmn_ctrl_props #(.ROWS(ROWS), .ROW_W(ROW_W)) u_props (.core_clk(core_clk),
  .sys_rst(sys_rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slice_ctl(slice_ctl),
  .encoder_count_msb_out(encoder_count_msb_out), .encoder_count_low_out(encoder_count_low_out),
  .shift_code_in(shift_code_in), .row_oe_n(row_oe_n), .shift_code_msb_in(shift_code_msb_in),
  .auto_normalize_select_count(auto_normalize_select_count), .auto_normalize_select_none(auto_normalize_select_none));
`default_nettype wire

/* File: bench/cmn_ctrl_bench.sv */
// Self-checking bench for the normalizer controller
`timescale 1ns/1ps
`default_nettype none
module cmn_ctrl_bench;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0, ev = 1'b0, ps = 1'b0;
  logic [63:0] mant = 64'h0;
  logic [31:0] reg_rdata, exp_q[$];
  logic [4:0] top, code;
  logic [3:0] msb, msb_in, oe_n, sel_oh;
  logic [15:0] low;
  logic [5:0] cnt;
  logic none;
  cmn_pkg::cmn_slice_ctl_t ctl;
  int fail_count = 0, n_compared = 0, e, bmax, prev;
  cmn_ctrl #(.ROWS(4)) uut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .encoder_shift_count_out(top), .encoder_count_msb_out(msb), .encoder_count_low_out(low),
    .elem_valid_in(ev), .pass_start_in(ps), .shift_code_in(code), .slice_ctl(ctl),
    .row_oe_n(oe_n), .shift_code_msb_in(msb_in), .auto_normalize_select_count(cnt), .auto_normalize_select_none(none));
  cmn_slice_model #(.ROWS(4)) u_model (.mant(mant), .sign(ctl.sign), .top_count(top),
    .msb(msb), .low(low));
  always #50 core_clk = ~core_clk;
  function automatic int lead(input logic [63:0] v, input int n);
    lead = n;
    for (int b = 64 - n; b < 64; b++)
      if (v[b])
        lead = 63 - b;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    n_compared++;
    if (got !== want)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    if (!w)
      exp_q.push_back(d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic finish_test();
    fail_count += exp_q.size(); // Reads never answered
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Read data taken against the oldest note
  always @(posedge core_clk)
  begin
    rd_q <= reg_rd;
    if (rd_q && exp_q.size() > 0)
      cmp(reg_rdata, exp_q.pop_front());
  end
  // Watchdog
  initial
  begin
    repeat (3000) @(posedge core_clk);
    fail_count++;
    finish_test();
  end
  // Main sequence
  initial
  begin
    void'($urandom(15));
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    cmp(ctl, 32'h12);
    @(posedge core_clk);
    for (int i = 0; i < 12; i++)
    begin
      bus(1'b1, cmn_pkg::REG_CTRL, {29'h0, i[0], 2'h0});
      mant <= {$urandom, $urandom} >> $urandom_range(40);
      repeat (4) @(posedge core_clk);
      e = lead(mant ^ {64{i[0]}}, 32);
      @(negedge core_clk);
      cmp(code, (e > 15) ? 15 : e);
      cmp(none, e > 15);
      cmp(ctl.sign, i[0]);
      cmp(cnt, (e > 15) ? 15 : e);
      cmp(ctl.output_half_select, 1'b1);
      @(posedge core_clk);
    end
    bus(1'b1, cmn_pkg::REG_CTRL, 32'h1);
    for (int i = 0; i < 14; i++)
    begin
      mant <= (i == 13) ? 64'h0 : {$urandom, $urandom} >> $urandom_range(63);
      repeat (4) @(posedge core_clk);
      e = lead(mant, 64);
      sel_oh = ~(4'h1 << ((e == 64) ? 3 : e / 16));
      cmp(oe_n, sel_oh);
      cmp(msb_in, sel_oh);
      bus(1'b0, cmn_pkg::REG_STATUS, (e == 64) ? 32'h1033f : 32'((e / 16) * 256 + e));
    end
    bus(1'b1, cmn_pkg::REG_CTRL, 32'h2);
    bmax = 0;
    for (int p = 0; p < 3; p++)
    begin
      ps <= 1'b1;
      @(posedge core_clk);
      ps <= 1'b0;
      prev = bmax;
      bmax = 0;
      for (int k = 0; k < 6; k++)
      begin
        ev <= 1'b1;
        mant <= {$urandom, $urandom} >> $urandom_range(36);
        @(posedge core_clk);
        e = lead(mant, 32);
        bmax = (e > 31) ? 31 : (e > bmax) ? e : bmax;
      end
      ev <= 1'b0;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      cmp(code, prev);
      cmp(ctl.output_half_select, 1'b0);
      @(posedge core_clk);
      bus(1'b0, cmn_pkg::REG_BLOCK_MAX, bmax);
    end
    bus(1'b1, cmn_pkg::REG_BLOCK_APPLY, 32'h13);
    bus(1'b1, cmn_pkg::REG_STATUS, 32'hffff);
    bus(1'b0, cmn_pkg::REG_BLOCK_APPLY, 32'h13);
    bus(1'b0, 4'h9, 32'h0);
    cmp(code, 32'h13);
    bus(1'b1, cmn_pkg::REG_CTRL, 32'h3);
    bus(1'b0, cmn_pkg::REG_CTRL, 32'h3);
    cmp(code, 32'h0);
    cmp(oe_n, 32'hf);
    repeat (2) @(posedge core_clk);
    finish_test();
  end
endmodule // cmn_ctrl_bench
`default_nettype wire
